// file: logic/pwa_map.svh
// register offsets, field positions and reset values of the pwm array
// Notes on behaviour
// RULE_01: parameter register reads doubled pattern
// RULE_02: open drain option has no effect
// RULE_03: duty write on wrap corrupts duty
// RULE_04: software writes duty just after overflow
// RULE_05: nonzero config while disabled locks busy
// RULE_06: software sets config only when enabled
// RULE_07: duty write drops that cycle's events
// RULE_08: software avoids duty writes near events
// RULE_09: version register returns fixed revision code
// RULE_10: timebase counts, wraps at limit, flags overflow
`ifndef PWA_MAP_SVH
`define PWA_MAP_SVH
`define PWA_ADDR_W 8
`define PWA_OFF_CTRL 8'h00
`define PWA_OFF_STATUS 8'h04
`define PWA_OFF_MASK 8'h08
`define PWA_OFF_PARAM 8'h0C
`define PWA_OFF_VERSION 8'h10
`define PWA_OFF_EVCNT 8'h14
`define PWA_OFF_DUTY0 8'h20
`define PWA_CTRL_EN_BIT 0
`define PWA_CTRL_OD_BIT 1
`define PWA_CTRL_TCLR_BIT 2
`define PWA_CTRL_SPREAD_BIT 3
`define PWA_CTRL_LIMIT_LSB 8
`define PWA_CTRL_LIMIT_MSB 15
`define PWA_ST_OVF_BIT 0
`define PWA_ST_BUSY_BIT 1
`define PWA_ST_EVDROP_BIT 2
`define PWA_PARAM_VALUE 32'h0000_2424
`define PWA_LIMIT_RESET 8'hFF
`define PWA_DUTY_RESET 8'h00
`define PWA_GARBLE 8'hA5
`endif

// file: logic/pwa_pkg.sv
// types shared by the pwm array files
package pwa_pkg;
    typedef logic [7:0] pwa_count_t;
    typedef enum logic [1:0] {
        PWA_IDLE = 2'b01,
        PWA_RUN = 2'b10
    } pwa_state_t;
endpackage

// file: logic/pwa_channel.sv
// one pwm channel: compare and event-driven output toggle
`include "pwa_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pwa_channel
    import pwa_pkg::*;
#(
    parameter int CW = 8
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic running,
    input wire logic [CW-1:0] count,
    input wire logic [CW-1:0] duty,
    input wire logic eventIn,
    output logic pinOut
);
    logic evInvert;
    logic next_evInvert;
    logic next_pinOut;

    always_comb
    begin
        next_evInvert = evInvert;
        // events flip polarity; gating happens upstream
        if (eventIn)
        begin
            next_evInvert = ~evInvert;
        end
        next_pinOut = running ? ((count < duty) ^ next_evInvert) : 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evInvert <= 1'b0;
            pinOut <= 1'b0;
        end
        else if (clkEn)
        begin
            evInvert <= next_evInvert;
            pinOut <= next_pinOut;
        end
    end
endmodule
`default_nettype wire

// file: logic/pwm_array_unit.sv
// pwm array top: registers, timebase, busy lockup, event gating, channels
`include "pwa_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pwm_array_unit
    import pwa_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter logic [31:0] VERSION_CODE = 32'h0000_0A17 // arbitrary value
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [`PWA_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [CHANNELS-1:0] periphEvent,
    output logic [CHANNELS-1:0] pinOut,
    output logic [CHANNELS-1:0] pinOutEn_b,
    output logic irq
);
    // ***************************************************
    // state
    // ***************************************************
    pwa_state_t state;
    pwa_state_t next_state;
    logic genEnable;
    logic openDrain;
    logic timebaseClear;
    logic spreadSel;
    pwa_count_t timebaseLimit;
    pwa_count_t count;
    logic [2:0] status;
    logic [2:0] mask;
    logic [15:0] evDropCount;
    pwa_count_t duty [CHANNELS];

    logic next_genEnable;
    logic next_openDrain;
    logic next_timebaseClear;
    logic next_spreadSel;
    pwa_count_t next_timebaseLimit;
    pwa_count_t next_count;
    logic [2:0] next_status;
    logic [2:0] next_mask;
    logic [15:0] next_evDropCount;
    logic [31:0] next_regRdata;

    logic ctrlWr;
    logic statusWr;
    logic dutyWr;
    logic wrapNow;
    logic running;
    logic badCfg;
    logic [CHANNELS-1:0] gatedEvent;

    assign running = (state == PWA_RUN);
    assign ctrlWr = regWr && (regAddr == `PWA_OFF_CTRL);
    assign statusWr = regWr && (regAddr == `PWA_OFF_STATUS);
    // wrap compare uses the stored limit, not a write landing this cycle
    assign wrapNow = running && (count == timebaseLimit); // RULE_10

    // ***************************************************
    // control, timebase and status
    // ***************************************************
    always_comb
    begin
        next_genEnable = genEnable;
        next_openDrain = openDrain;
        next_timebaseClear = 1'b0;
        next_spreadSel = spreadSel;
        next_timebaseLimit = timebaseLimit;
        next_mask = mask;
        badCfg = 1'b0;
        if (ctrlWr)
        begin
            next_genEnable = regWdata[`PWA_CTRL_EN_BIT];
            next_openDrain = regWdata[`PWA_CTRL_OD_BIT];
            next_timebaseClear = regWdata[`PWA_CTRL_TCLR_BIT];
            next_spreadSel = regWdata[`PWA_CTRL_SPREAD_BIT];
            next_timebaseLimit = regWdata[`PWA_CTRL_LIMIT_MSB:`PWA_CTRL_LIMIT_LSB];
            // nonzero sync field with enable low and not being set: busy sticks
            badCfg = !genEnable && !regWdata[`PWA_CTRL_EN_BIT] &&
                ((regWdata[`PWA_CTRL_LIMIT_MSB:`PWA_CTRL_LIMIT_LSB] != 8'h00) ||
                regWdata[`PWA_CTRL_SPREAD_BIT] || regWdata[`PWA_CTRL_TCLR_BIT]); // RULE_05
        end
        if (regWr && (regAddr == `PWA_OFF_MASK))
        begin
            next_mask = regWdata[2:0];
        end
        next_state = state;
        case (state)
            PWA_IDLE:
            begin
                if (next_genEnable)
                begin
                    next_state = PWA_RUN;
                end
            end
            PWA_RUN:
            begin
                if (!next_genEnable)
                begin
                    next_state = PWA_IDLE;
                end
            end
            default:
            begin
                next_state = PWA_IDLE;
            end
        endcase
        next_count = count;
        if (timebaseClear || !running)
        begin
            next_count = 8'h00;
        end
        else if (wrapNow)
        begin
            next_count = 8'h00; // RULE_10
        end
        else
        begin
            next_count = count + 8'h01;
        end
        next_status = status;
        if (statusWr)
        begin
            next_status[`PWA_ST_OVF_BIT] = status[`PWA_ST_OVF_BIT] &
                ~regWdata[`PWA_ST_OVF_BIT];
            next_status[`PWA_ST_EVDROP_BIT] = status[`PWA_ST_EVDROP_BIT] &
                ~regWdata[`PWA_ST_EVDROP_BIT];
        end
        // set wins over a clear in the same cycle
        if (wrapNow)
        begin
            next_status[`PWA_ST_OVF_BIT] = 1'b1; // RULE_10
        end
        if (badCfg)
        begin
            next_status[`PWA_ST_BUSY_BIT] = 1'b1; // RULE_05
        end
        if (dutyWr && (periphEvent != '0))
        begin
            next_status[`PWA_ST_EVDROP_BIT] = 1'b1;
        end
        // drop counter rolls over silently at its width
        next_evDropCount = evDropCount;
        if (dutyWr && (periphEvent != '0))
        begin
            next_evDropCount = evDropCount + 16'h0001;
        end
    end

    // busy only clears by reset: the lockup is kept on purpose
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= PWA_IDLE;
            genEnable <= 1'b0;
            openDrain <= 1'b0;
            timebaseClear <= 1'b0;
            spreadSel <= 1'b0;
            timebaseLimit <= `PWA_LIMIT_RESET;
            count <= 8'h00;
            status <= 3'h0;
            mask <= 3'h0;
            evDropCount <= 16'h0000;
        end
        else if (clkEn)
        begin
            state <= next_state;
            genEnable <= next_genEnable;
            openDrain <= next_openDrain;
            timebaseClear <= next_timebaseClear;
            spreadSel <= next_spreadSel;
            timebaseLimit <= next_timebaseLimit;
            count <= next_count;
            status <= next_status;
            mask <= next_mask;
            evDropCount <= next_evDropCount;
        end
    end

    // ***************************************************
    // duty registers, event gating and channels
    // ***************************************************
    logic [CHANNELS-1:0] dutyHit;
    assign dutyWr = |dutyHit;
    // a duty write in this cycle discards every incoming event
    assign gatedEvent = dutyWr ? '0 : periphEvent; // RULE_07

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_ch
            pwa_count_t next_duty;
            assign dutyHit[gi] = regWr &&
                (regAddr == `PWA_OFF_DUTY0 + 8'(4 * gi));
            always_comb
            begin
                next_duty = duty[gi];
                if (dutyHit[gi])
                begin
                    // write on the wrap cycle stores a garbled value
                    next_duty = wrapNow ? (regWdata[7:0] ^ `PWA_GARBLE) : regWdata[7:0]; // RULE_03
                end
            end
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    duty[gi] <= `PWA_DUTY_RESET;
                end
                else if (clkEn)
                begin
                    duty[gi] <= next_duty;
                end
            end
            pwa_channel #(
                .CW(8)
            ) u_ch (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .clkEn(clkEn),
                .running(running),
                .count(count),
                .duty(duty[gi]),
                .eventIn(gatedEvent[gi]),
                .pinOut(pinOut[gi])
            );
            // open drain select is ignored: always push-pull, enable low = drive
            assign pinOutEn_b[gi] = 1'b0; // RULE_02
        end
    endgenerate

    assign irq = |(status & mask);

    // ***************************************************
    // read port
    // ***************************************************
    always_comb
    begin
        // answer stands one cycle, zero otherwise, so no stale data lingers
        next_regRdata = 32'h0000_0000;
        if (regRd)
        begin
            if (regAddr == `PWA_OFF_CTRL)
            begin
                next_regRdata = {16'h0000, timebaseLimit, 4'h0, spreadSel, 1'b0,
                    openDrain, genEnable};
            end
            else if (regAddr == `PWA_OFF_STATUS)
            begin
                next_regRdata = {29'h0, status};
            end
            else if (regAddr == `PWA_OFF_MASK)
            begin
                next_regRdata = {29'h0, mask};
            end
            else if (regAddr == `PWA_OFF_PARAM)
            begin
                next_regRdata = `PWA_PARAM_VALUE; // RULE_01
            end
            else if (regAddr == `PWA_OFF_VERSION)
            begin
                next_regRdata = VERSION_CODE; // RULE_09
            end
            else if (regAddr == `PWA_OFF_EVCNT)
            begin
                next_regRdata = {16'h0000, evDropCount};
            end
            else
            begin
                for (int i = 0; i < CHANNELS; i++)
                begin
                    if (regAddr == `PWA_OFF_DUTY0 + 8'(4 * i))
                    begin
                        next_regRdata = {24'h0, duty[i]};
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdata <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            regRdata <= next_regRdata;
        end
    end
endmodule
`default_nettype wire

// file: testbench/pwa_event_src.sv
// peripheral event source model facing the pwm array channels
`timescale 1ns/1ns
`default_nettype none
module pwa_event_src
#(
    parameter int CHANNELS = 4
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [CHANNELS-1:0] fire,
    output logic [CHANNELS-1:0] periphEvent
);
    // ****************************************
    // pulse shaping
    // ****************************************
    // a held request still gives one pulse, as a real event line does
    logic [CHANNELS-1:0] fireDly;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fireDly <= '0;
            periphEvent <= '0;
        end
        else
        begin
            fireDly <= fire;
            periphEvent <= fire & ~fireDly;
        end
    end
endmodule
`default_nettype wire

// file: testbench/pwa_unit_asserts.sv
// concurrent checks on the pwm array unit ports
`include "pwa_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pwa_unit_asserts
    import pwa_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter logic [31:0] VERSION_CODE = 32'h0000_0A17
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [`PWA_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic [CHANNELS-1:0] periphEvent,
    input wire logic [CHANNELS-1:0] pinOut,
    input wire logic [CHANNELS-1:0] pinOutEn_b,
    input wire logic irq
);
    // ****************************************
    // shadow state seen from the bus
    // ****************************************
    logic enShadow, next_enShadow, lockSeen, next_lockSeen, dropSeen, next_dropSeen;
    logic [2:0] maskShadow, next_maskShadow;
    logic ctrlWr, stWr, dutyWr;
    assign ctrlWr = regWr && clkEn && regAddr == `PWA_OFF_CTRL;
    assign stWr = regWr && clkEn && regAddr == `PWA_OFF_STATUS;
    assign dutyWr = regWr && clkEn && regAddr >= `PWA_OFF_DUTY0
        && regAddr < 8'(32 + 4 * CHANNELS) && regAddr[1:0] == 2'b00;
    always_comb
    begin
        next_enShadow = ctrlWr ? regWdata[0] : enShadow;
        next_lockSeen = lockSeen | (ctrlWr && !enShadow && !regWdata[0]
            && (regWdata[15:8] != 8'h00 || regWdata[2] || regWdata[3]));
        next_dropSeen = (dutyWr && periphEvent != '0) | (dropSeen && !(stWr && regWdata[2]));
        next_maskShadow = (regWr && clkEn && regAddr == `PWA_OFF_MASK) ? regWdata[2:0] : maskShadow;
    end
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enShadow <= 1'b0;
            lockSeen <= 1'b0;
            dropSeen <= 1'b0;
            maskShadow <= 3'b000;
        end
        else
        begin
            enShadow <= next_enShadow;
            lockSeen <= next_lockSeen;
            dropSeen <= next_dropSeen;
            maskShadow <= next_maskShadow;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence readOf(logic [7:0] a);
        regRd && clkEn && regAddr == a;
    endsequence
    od_drive_a: assert property (pinOutEn_b == '0)
        else $error("pin enable released");
    read_idle_a: assert property (clkEn && !regRd |=> regRdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    param_read_a: assert property (readOf(`PWA_OFF_PARAM) |=> regRdata == `PWA_PARAM_VALUE)
        else $error("parameter value wrong");
    version_read_a: assert property (readOf(`PWA_OFF_VERSION) |=> regRdata == VERSION_CODE)
        else $error("version value wrong");
    busy_lock_a: assert property ((lockSeen ##0 readOf(`PWA_OFF_STATUS)) |=> regRdata[1])
        else $error("busy not stuck");
    busy_clear_a: assert property ((!lockSeen ##0 readOf(`PWA_OFF_STATUS)) |=> !regRdata[1])
        else $error("busy set without cause");
    drop_flag_a: assert property ((dropSeen ##0 readOf(`PWA_OFF_STATUS)) |=> regRdata[2])
        else $error("event drop flag missing");
    idle_low_a: assert property (!enShadow && !$past(enShadow) |-> pinOut == '0)
        else $error("output active while disabled");
    mask_gate_a: assert property (maskShadow == 3'b000 |-> !irq)
        else $error("irq with all masked");
endmodule
bind pwm_array_unit pwa_unit_asserts #(.CHANNELS(CHANNELS), .VERSION_CODE(VERSION_CODE))
    i_pwa_unit_asserts (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .periphEvent(periphEvent), .pinOut(pinOut), .pinOutEn_b(pinOutEn_b), .irq(irq));
`default_nettype wire

// file: testbench/pwm_array_unit_test.sv
// self-checking bench of the pwm array unit
`include "pwa_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pwm_array_unit_test
    import pwa_pkg::*;
;
    localparam logic [31:0] VC = 32'h0000_5C3E; // arbitrary value
    typedef struct packed { logic [7:0] addr; logic [31:0] exp; } pwa_row_t;
    pwa_row_t rows [7] = '{'{`PWA_OFF_CTRL, 32'h0000_FF00}, '{`PWA_OFF_STATUS, 32'h0000_0000},
        '{`PWA_OFF_PARAM, `PWA_PARAM_VALUE}, '{`PWA_OFF_VERSION, VC},
        '{`PWA_OFF_EVCNT, 32'h0000_0000}, '{`PWA_OFF_DUTY0, 32'h0000_0000},
        '{8'hFC, 32'h0000_0000}};
    logic sys_clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0, irq;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000, regRdata, v;
    logic [3:0] fire = 4'h0, periphEvent, pinOut, pinOutEn_b;
    int nErrors = 0, totalChecks = 0, hi;
    always #25 sys_clk = ~sys_clk;
    pwm_array_unit #(.CHANNELS(4), .VERSION_CODE(VC)) i_pwm_array_unit (.sys_clk(sys_clk),
        .rst_b(rst_b), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .periphEvent(periphEvent), .pinOut(pinOut),
        .pinOutEn_b(pinOutEn_b), .irq(irq));
    pwa_event_src #(.CHANNELS(4)) i_pwa_event_src (.sys_clk(sys_clk), .rst_b(rst_b),
        .fire(fire), .periphEvent(periphEvent));
    // ****************************************
    // bus and check tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            nErrors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rdRaw(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    // duty writes go right after a wrap so they never land on one
    task automatic waitWrap();
        wr(`PWA_OFF_STATUS, 32'h0000_0001);
        v = '0;
        for (int i = 0; i < 20 && v[0] !== 1'b1; i++)
            rdRaw(`PWA_OFF_STATUS, v);
        chk("overflow flag", 32'h0000_0001, 32'(v[0]));
    endtask
    task automatic wrapUp();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        repeat (8) @(posedge sys_clk);
        chk("pins in reset", 32'h0000_0000, 32'({pinOut, pinOutEn_b, irq}));
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rdRaw(rows[i].addr, v);
            chk("register read", rows[i].exp, v);
        end
        wr(`PWA_OFF_MASK, 32'h0000_0004);
        wr(`PWA_OFF_CTRL, 32'h0000_0F01);
        waitWrap();
        wr(`PWA_OFF_DUTY0, 32'h0000_0005);
        repeat (20) @(posedge sys_clk);
        hi = 0;
        repeat (32)
        begin
            @(posedge sys_clk);
            #1;
            hi += (pinOut[0] === 1'b1);
        end
        chk("duty high cycles", 32'd10, 32'(hi));
        waitWrap();
        @(posedge sys_clk);
        fire <= 4'b0010;
        wr(`PWA_OFF_DUTY0 + 8'h04, 32'h0000_0000);
        repeat (4) @(posedge sys_clk);
        #1;
        chk("dropped event pin", 32'h0, 32'(pinOut[1]));
        chk("irq on drop", 32'h1, 32'(irq));
        rdRaw(`PWA_OFF_EVCNT, v);
        chk("drop count", 32'h0000_0001, v);
        rdRaw(`PWA_OFF_STATUS, v);
        chk("drop flag", 32'h1, 32'(v[`PWA_ST_EVDROP_BIT]));
        fire <= 4'b0000;
        wr(`PWA_OFF_STATUS, 32'h0000_0004);
        #1;
        chk("irq cleared", 32'h0, 32'(irq));
        fire <= 4'b0010;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("kept event pin", 32'h1, 32'(pinOut[1]));
        // limit zero wraps every cycle, so the next duty write lands on a wrap
        wr(`PWA_OFF_CTRL, 32'h0000_000F);
        wr(`PWA_OFF_DUTY0 + 8'h08, 32'h0000_0033);
        rdRaw(`PWA_OFF_DUTY0 + 8'h08, v);
        chk("duty on wrap", {24'h0, 8'h33 ^ `PWA_GARBLE}, v);
        rdRaw(`PWA_OFF_CTRL, v);
        chk("ctrl readback", 32'h0000_000B, v);
        chk("pin enable", 32'h0, 32'(pinOutEn_b));
        wr(`PWA_OFF_CTRL, 32'h0000_0000);
        rdRaw(`PWA_OFF_STATUS, v);
        chk("busy after disable", 32'h0, 32'(v[1]));
        wr(`PWA_OFF_CTRL, 32'h0000_0400);
        wr(`PWA_OFF_STATUS, 32'h0000_0002);
        rdRaw(`PWA_OFF_STATUS, v);
        chk("busy stuck", 32'h1, 32'(v[1]));
        @(posedge sys_clk);
        fire <= 4'b0000;
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdRaw(`PWA_OFF_STATUS, v);
        chk("busy after reset", 32'h0, 32'(v[1]));
        chk("pins after reset", 32'h0000_0000, 32'({pinOut, pinOutEn_b, irq}));
        // clock enable low must swallow a write
        @(posedge sys_clk);
        clkEn <= 1'b0;
        wr(`PWA_OFF_MASK, 32'h0000_0007);
        clkEn <= 1'b1;
        rdRaw(`PWA_OFF_MASK, v);
        chk("mask frozen", 32'h0000_0000, v);
        wrapUp();
    end
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        nErrors++;
        wrapUp();
    end
endmodule
`default_nettype wire
